// ==== hdl/srg_consts.vh ====
// constants for the special register access guard
`ifndef SRG_CONSTS_VH
`define SRG_CONSTS_VH
`define SRG_MODE_PRIV      2'h0
`define SRG_MODE_USER      2'h1
`define SRG_MODE_CTLESS    2'h2
`define SRG_MODE_TEST      2'h3
`define SRG_CLS_CPU        2'h0
`define SRG_CLS_MMU        2'h1
`define SRG_CLS_PERIPH     2'h2
`define SRG_CLS_FAB        2'h3
`define SRG_ADDR_MMU_LO    8'h00
`define SRG_ADDR_MMU_HI    8'h0F
`define SRG_ADDR_CPU_LO    8'h10
`define SRG_ADDR_CPU_HI    8'h1F
`define SRG_ADDR_FAB_LO    8'h20
`define SRG_ADDR_FAB_HI    8'h27
`define SRG_ADDR_PER_LO    8'h40
`define SRG_ADDR_SEG_PTR   8'h00
`define SRG_ADDR_UEN       8'h01
`define SRG_ADDR_CEN       8'h02
`define SRG_RST_VALUE      8'h00
`define SRG_RST_ENABLES    8'h00
`endif

// ==== hdl/srg_reg_cell.v ====
// one special register cell with fixed reset value
`timescale 1ns/100ps
`include "srg_consts.vh"
module srg_reg_cell #(
  parameter W = 8
) (
  input  wire         sys_clk,
  input  wire         resetn,
  input  wire         clk_en,
  input  wire         wr_en,
  input  wire [W-1:0] wr_data,
  output reg  [W-1:0] value_q
);
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      value_q <= `SRG_RST_VALUE;
    end else if (clk_en && wr_en) begin
      value_q <= wr_data;
    end
  end
endmodule

// ==== hdl/srg_access_guard.v ====
// special register access guard between cpu core and register cells
`timescale 1ns/100ps
`include "srg_consts.vh"
module srg_access_guard #(
  parameter N_PER = 8
) (
  input  wire       sys_clk,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire [1:0] cpu_mode,
  input  wire       acc_valid,
  input  wire       acc_write,
  input  wire [7:0] acc_addr,
  input  wire [7:0] acc_wdata,
  output reg  [7:0] acc_rdata,
  output reg        acc_done,
  output reg        acc_violation
);
  ////////////////////////////////////////////////////////////////////////
  // address classification; attributes are hardwired except the peripheral enables
  reg  [1:0] cls;
  reg        hit;
  reg        allowed;
  reg  [7:0] rd_mux;
  reg  [7:0] fab_q [0:7];
  wire [7:0] seg_q;
  wire [7:0] uen_q;
  wire [7:0] cen_q;
  wire [7:0] cpu_q [0:15];
  wire [7:0] per_q [0:N_PER-1];
  wire [2:0] per_idx = acc_addr[2:0];
  wire       per_hit = (acc_addr >= `SRG_ADDR_PER_LO) &&
                       (acc_addr < (`SRG_ADDR_PER_LO + N_PER));

  always @* begin
    if (acc_addr <= `SRG_ADDR_MMU_HI) begin
      cls = `SRG_CLS_MMU;
    end else if (acc_addr <= `SRG_ADDR_CPU_HI) begin
      cls = `SRG_CLS_CPU;
    end else if (acc_addr <= `SRG_ADDR_FAB_HI) begin
      cls = `SRG_CLS_FAB;
    end else begin
      cls = `SRG_CLS_PERIPH;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mapped addresses; the rest of the mmu window and the gap below the
  // peripherals answer with a violation
  always @* begin
    hit = 1'b0;
    case (cls)
      `SRG_CLS_MMU: begin
        hit = (acc_addr <= `SRG_ADDR_CEN);
      end
      `SRG_CLS_CPU: begin
        hit = 1'b1;
      end
      `SRG_CLS_FAB: begin
        hit = 1'b1;
      end
      `SRG_CLS_PERIPH: begin
        hit = per_hit;
      end
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode and per-peripheral grants
  wire       mode_priv   = (cpu_mode == `SRG_MODE_PRIV);
  wire       mode_user   = (cpu_mode == `SRG_MODE_USER);
  wire       mode_ctless = (cpu_mode == `SRG_MODE_CTLESS);
  wire       mode_test   = (cpu_mode == `SRG_MODE_TEST);
  wire       per_user    = uen_q[per_idx];
  wire       per_ctless  = cen_q[per_idx];

  ////////////////////////////////////////////////////////////////////////
  // access decision per mode
  always @* begin
    allowed = 1'b0;
    case (cls)
      `SRG_CLS_MMU: begin
        // factory test gets no way around the partition setup
        allowed = mode_priv;
      end
      `SRG_CLS_CPU: begin
        allowed = 1'b1;
      end
      `SRG_CLS_PERIPH: begin
        if (mode_priv || mode_test) begin
          allowed = 1'b1;
        end else if (mode_user) begin
          allowed = per_user;
        end else if (mode_ctless) begin
          allowed = per_ctless;
        end
      end
      `SRG_CLS_FAB: begin
        // stored once at the end of factory test, readable except contactless
        if (acc_write) begin
          allowed = mode_test;
        end else begin
          allowed = !mode_ctless;
        end
      end
      default: allowed = 1'b0;
    endcase
    if (!hit) begin
      allowed = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write strobes; a denied write never reaches a cell
  wire       wr_ok  = acc_valid && acc_write && allowed;
  wire       seg_wr = wr_ok && (acc_addr == `SRG_ADDR_SEG_PTR);
  wire       uen_wr = wr_ok && (acc_addr == `SRG_ADDR_UEN);
  wire       cen_wr = wr_ok && (acc_addr == `SRG_ADDR_CEN);
  wire       cpu_wr = wr_ok && (cls == `SRG_CLS_CPU);
  wire       per_wr = wr_ok && per_hit;
  wire       fab_wr = wr_ok && (cls == `SRG_CLS_FAB);

  ////////////////////////////////////////////////////////////////////////
  // register cells
  srg_reg_cell #(.W(8)) u_seg (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .wr_en   (seg_wr),
    .wr_data (acc_wdata),
    .value_q (seg_q)
  );
  // only changeable attributes: unprivileged and contactless enables
  srg_reg_cell #(.W(8)) u_uen (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .wr_en   (uen_wr),
    .wr_data (acc_wdata),
    .value_q (uen_q)
  );
  srg_reg_cell #(.W(8)) u_cen (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .wr_en   (cen_wr),
    .wr_data (acc_wdata),
    .value_q (cen_q)
  );

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_cpu
      srg_reg_cell #(.W(8)) u_cell (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .wr_en   (cpu_wr && (acc_addr[3:0] == g)),
        .wr_data (acc_wdata),
        .value_q (cpu_q[g])
      );
    end
    for (g = 0; g < N_PER; g = g + 1) begin : g_per
      srg_reg_cell #(.W(8)) u_cell (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .wr_en   (per_wr && (per_idx == g)),
        .wr_data (acc_wdata),
        .value_q (per_q[g])
      );
    end
  endgenerate

  // fabrication data has no reset so the factory values survive it
  always @(posedge sys_clk) begin
    if (clk_en && fab_wr) begin
      fab_q[acc_addr[2:0]] <= acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always @* begin
    rd_mux = 8'h00;
    case (cls)
      `SRG_CLS_MMU: begin
        if (acc_addr == `SRG_ADDR_SEG_PTR) begin
          rd_mux = seg_q;
        end else if (acc_addr == `SRG_ADDR_UEN) begin
          rd_mux = uen_q;
        end else if (acc_addr == `SRG_ADDR_CEN) begin
          rd_mux = cen_q;
        end
      end
      `SRG_CLS_CPU: begin
        rd_mux = cpu_q[acc_addr[3:0]];
      end
      `SRG_CLS_FAB: begin
        rd_mux = fab_q[acc_addr[2:0]];
      end
      `SRG_CLS_PERIPH: begin
        if (per_hit) begin
          rd_mux = per_q[per_idx];
        end
      end
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next answer; denied or unmapped reads return zero, never protected content
  wire       done_d  = acc_valid;
  wire       viol_d  = acc_valid && !allowed;
  wire [7:0] rdata_d = (acc_valid && !acc_write && allowed) ? rd_mux : 8'h00;

  // answer stands one enabled cycle; a low enable freezes it
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_rdata     <= 8'h00;
      acc_done      <= 1'b0;
      acc_violation <= 1'b0;
    end else if (clk_en) begin
      acc_rdata     <= rdata_d;
      acc_done      <= done_d;
      acc_violation <= viol_d;
    end
  end
endmodule

// ==== testbench/srg_access_guard_chk.sv ====
// assertions on the access guard ports
`timescale 1ns/100ps
module srg_chk #(
  parameter N_PER = 8
) (
  input wire       sys_clk,
  input wire       resetn,
  input wire       clk_en,
  input wire [1:0] cpu_mode,
  input wire       acc_valid,
  input wire       acc_write,
  input wire [7:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire [7:0] acc_rdata,
  input wire       acc_done,
  input wire       acc_violation
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence req_s;
    acc_valid && clk_en;
  endsequence
  done_follows_a: assert property (req_s |=> acc_done) else $error("no done");
  no_spur_a: assert property (clk_en && !acc_valid |=> !acc_done) else $error("spurious done");
  mmu_deny_a: assert property (req_s ##0 (cpu_mode != 2'h0 && acc_addr <= 8'h0F) |=>
    acc_violation) else $error("mmu open");
  mmu_open_a: assert property (req_s ##0 (cpu_mode == 2'h0 && acc_addr <= 8'h02) |=>
    !acc_violation) else $error("mmu closed");
  cpu_open_a: assert property (req_s ##0 (acc_addr[7:4] == 4'h1) |=> !acc_violation)
    else $error("cpu reg closed");
  fab_write_a: assert property (req_s ##0 (acc_write && cpu_mode != 2'h3 &&
    acc_addr[7:3] == 5'h04) |=> acc_violation) else $error("fab write open");
  fab_read_a: assert property (req_s ##0 (!acc_write && cpu_mode != 2'h2 &&
    acc_addr[7:3] == 5'h04) |=> !acc_violation) else $error("fab read closed");
  per_full_a: assert property (req_s ##0 (cpu_mode[0] == cpu_mode[1] && acc_addr >= 8'h40 &&
    acc_addr < 8'h40 + N_PER) |=> !acc_violation) else $error("periph closed");
  unmapped_a: assert property (req_s ##0 (acc_addr >= 8'h40 + N_PER) |=> acc_violation)
    else $error("unmapped open");
  deny_zero_a: assert property (acc_violation |-> acc_done && acc_rdata == 8'h00)
    else $error("denied data");
  hole_deny_a: assert property (req_s ##0 ((acc_addr > 8'h02 && acc_addr < 8'h10) ||
    (acc_addr > 8'h27 && acc_addr < 8'h40)) |=> acc_violation) else $error("hole open");
  rst_quiet_a: assert property ($rose(resetn) |-> !acc_done && !acc_violation &&
    acc_rdata == 8'h00) else $error("reset answer");
  frz_hold_a: assert property (!clk_en |=> $stable(acc_done) && $stable(acc_violation) &&
    $stable(acc_rdata)) else $error("freeze broken");
endmodule
bind srg_access_guard srg_chk #(.N_PER(N_PER)) chk_u (
  .sys_clk       (sys_clk),
  .resetn        (resetn),
  .clk_en        (clk_en),
  .cpu_mode      (cpu_mode),
  .acc_valid     (acc_valid),
  .acc_write     (acc_write),
  .acc_addr      (acc_addr),
  .acc_wdata     (acc_wdata),
  .acc_rdata     (acc_rdata),
  .acc_done      (acc_done),
  .acc_violation (acc_violation)
);

// ==== testbench/srg_cpu_model.sv ====
// cpu core model issuing register accesses
`timescale 1ns/100ps
module srg_cpu_model (
  input  wire       sys_clk,
  input  wire       acc_done,
  input  wire       acc_violation,
  input  wire [7:0] acc_rdata,
  output reg        acc_valid,
  output reg        acc_write,
  output reg  [7:0] acc_addr,
  output reg  [7:0] acc_wdata
);
  initial {acc_valid, acc_write, acc_addr, acc_wdata} = 18'h0;
  task xfer(input w, input [7:0] a, input [7:0] d, output [9:0] res);
    @(negedge sys_clk);
    {acc_valid, acc_write, acc_addr, acc_wdata} = {1'b1, w, a, d};
    @(negedge sys_clk);
    // released lines inverted so stale values cannot pass
    {acc_valid, acc_write, acc_addr, acc_wdata} = {1'b0, ~w, ~a, ~d};
    res = {acc_done, acc_violation, acc_rdata};
  endtask
endmodule

// ==== testbench/srg_access_guard_bench.sv ====
// self-checking bench for the access guard
`timescale 1ns/100ps
module srg_access_guard_bench;
  reg        sys_clk = 1'b0;
  reg        resetn = 1'b0;
  reg  [1:0] cpu_mode = 2'h0;
  reg        clk_en = 1'b1;
  wire       acc_valid, acc_write, acc_done, acc_violation;
  wire [7:0] acc_addr, acc_wdata, acc_rdata;
  integer    failures = 0, n_tests = 0, seed = 32'h4123, i;
  reg  [7:0] mem [0:255];
  reg  [9:0] res;
  reg [31:0] r;
  srg_access_guard dut_u (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .clk_en        (clk_en),
    .cpu_mode      (cpu_mode),
    .acc_valid     (acc_valid),
    .acc_write     (acc_write),
    .acc_addr      (acc_addr),
    .acc_wdata     (acc_wdata),
    .acc_rdata     (acc_rdata),
    .acc_done      (acc_done),
    .acc_violation (acc_violation)
  );
  srg_cpu_model model_u (
    .sys_clk       (sys_clk),
    .acc_done      (acc_done),
    .acc_violation (acc_violation),
    .acc_rdata     (acc_rdata),
    .acc_valid     (acc_valid),
    .acc_write     (acc_write),
    .acc_addr      (acc_addr),
    .acc_wdata     (acc_wdata)
  );
  initial forever #50 sys_clk = ~sys_clk;
  function deny(input [1:0] fm, input fw, input [7:0] fa);
    if (fa <= 8'h0F) deny = fm != 2'h0 || fa > 8'h02;
    else if (fa <= 8'h1F) deny = 1'b0;
    else if (fa <= 8'h27) deny = fw ? fm != 2'h3 : fm == 2'h2;
    else if (fa < 8'h40 || fa > 8'h47) deny = 1'b1;
    else if (fm[0] ^ fm[1]) deny = !mem[fm][fa[2:0]];
    else deny = 1'b0;
  endfunction
  task chk_bit(input [8*5:1] nm, input exp, input got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected %0s exp %b got %b", nm, exp, got);
    end
  endtask
  task chk_byte(input [8*5:1] nm, input [7:0] exp, input [7:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected %0s exp %h got %h", nm, exp, got);
    end
  endtask
  task op(input [1:0] om, input ow, input [7:0] oa, input [7:0] od);
    reg x;
    x = deny(om, ow, oa);
    cpu_mode = om;
    model_u.xfer(ow, oa, od, res);
    chk_bit("done", 1'b1, res[9]);
    chk_bit("viol", x, res[8]);
    chk_byte("rdata", (x || ow) ? 8'h00 : mem[oa], res[7:0]);
    if (!x && ow) mem[oa] = od;
  endtask
  // a request under a low enable is not taken and the last answer stands
  task frz(input [7:0] fa, input [7:0] fd);
    op(2'h0, 1'b0, fa, 8'h00);
    clk_en = 1'b0;
    model_u.xfer(1'b1, fa, fd, res);
    clk_en = 1'b1;
    chk_bit("done", 1'b1, res[9]);
    chk_bit("viol", 1'b0, res[8]);
    chk_byte("rdata", mem[fa], res[7:0]);
    op(2'h0, 1'b0, fa, 8'h00);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    op(2'h1, 1'b0, 8'h40, 8'h00);
    op(2'h1, 1'b1, 8'h00, 8'h5A);
    op(2'h0, 1'b0, 8'h00, 8'h00);
    op(2'h1, 1'b1, 8'h01, 8'hFF);
    op(2'h0, 1'b1, 8'h01, 8'h05);
    op(2'h1, 1'b0, 8'h42, 8'h00);
    op(2'h1, 1'b0, 8'h41, 8'h00);
    op(2'h0, 1'b1, 8'h02, 8'h02);
    op(2'h2, 1'b1, 8'h41, 8'h3C);
    // fab data undefined until stored, so store all first
    for (i = 0; i < 8; i = i + 1) op(2'h3, 1'b1, {5'h04, i[2:0]}, 8'hA0 ^ i[7:0]);
    for (i = 0; i < 400; i = i + 1) begin
      r = $random(seed);
      op(r[1:0], r[2], {1'b0, r[14:8]}, r[23:16]);
    end
    op(2'h0, 1'b1, 8'h00, 8'h33);
    op(2'h0, 1'b0, 8'h00, 8'h00);
    frz(8'h10, 8'hC3);
    frz(8'h01, 8'hFF);
    // mid-run reset: cells return to defaults, fabrication bytes persist
    @(negedge sys_clk) resetn = 1'b0;
    @(negedge sys_clk) resetn = 1'b1;
    for (i = 0; i < 256; i = i + 1) if (i < 32 || i > 39) mem[i] = 8'h00;
    for (i = 0; i < 3; i = i + 1) op(2'h0, 1'b0, i[7:0], 8'h00);
    for (i = 0; i < 16; i = i + 1) op(2'h0, 1'b0, 8'h10 | i[7:0], 8'h00);
    for (i = 0; i < 8; i = i + 1) op({1'b0, i[0]}, 1'b0, 8'h40 | i[7:0], 8'h00);
    op(2'h1, 1'b0, 8'h20, 8'h00);
    op(2'h0, 1'b0, 8'h05, 8'h00);
    op(2'h0, 1'b0, 8'hFF, 8'h00);
    give_verdict;
  end
endmodule
